// >>> verilog/fiap_pkg.sv
`default_nettype none
package fiap_pkg;
  // clock and unlock window timing
  localparam int CLK_NS = 5;
  localparam int UNLOCK_NS = 5120;
  localparam int UNLOCK_CYC = (UNLOCK_NS + CLK_NS - 1) / CLK_NS;
  // array geometry
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 5;
  localparam int PAGE_WORDS = 32;
  localparam logic [IDX_W-1:0] IDX_LAST = 5'h1f;
  localparam logic [IDX_W-1:0] IDX_FIRST = 5'h00;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
  localparam logic [7:0] OFS_DATA_LOW = 8'h10;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h14;
  localparam logic [7:0] OFS_KEY_BASE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam int KEY_NUM = 6;
  // control 0 and control 2 bit positions
  localparam int B_RGO = 0;
  localparam int B_REN = 1;
  localparam int B_PGO = 2;
  localparam int B_TRIG = 3;
  localparam int B_MODE = 4;
  localparam int B_UNL = 7;
  localparam int B_CLR = 0;
  // modes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // key pattern: key1 low, key1 high, key2 low, key2 high, key3 low, key3 high
  localparam logic [47:0] KEY_PATTERN = 48'h40c3_090d_0400;
  typedef enum logic [1:0] {
    CMD_READ = 2'h0,
    CMD_ERASE = 2'h1,
    CMD_PROG = 2'h2
  } fiap_cmd_type;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_ERASE = 5'h02,
    S_PSCAN = 5'h04,
    S_PWAIT = 5'h08,
    S_READ = 5'h10
  } fiap_state_type;
  typedef struct packed {
    logic valid;
    fiap_cmd_type cmd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } fiap_freq_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } fiap_wbreq_type;
endpackage
`default_nettype wire

// >>> verilog/fiap_buffer.sv
`default_nettype none
module fiap_buffer #(
  parameter int WORDS = fiap_pkg::PAGE_WORDS,
  parameter int WIDTH = fiap_pkg::WORD_W,
  parameter int IW = fiap_pkg::IDX_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // load side
  input wire logic clr,
  input wire logic wrEn,
  input wire logic [IW-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  // drain side
  input wire logic [IW-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData,
  output logic rdValid
);
  logic [WIDTH-1:0] mem [WORDS];
  logic [WORDS-1:0] loaded;

  // whole buffer clear wins over a load
  always_ff @(posedge mclk) begin
    if (sys_rst || clr) begin
      loaded <= '0;
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '0;
      end
    end else if (wrEn) begin
      loaded[wrIdx] <= 1'b1;
      mem[wrIdx] <= wrData;
    end
  end

  assign rdData = mem[rdIdx];
  assign rdValid = loaded[rdIdx];

  a_clear_empties: assert property (@(posedge mclk) disable iff (sys_rst)
    clr |=> loaded == '0) else $error("buffer not empty after clear");
endmodule
`default_nettype wire

// >>> verilog/fiap_ctrl.sv
`default_nettype none
module fiap_ctrl #(
  parameter int UNLOCK_CYC = fiap_pkg::UNLOCK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // wishbone slave
  input wire fiap_pkg::fiap_wbreq_type wbReq,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // flash array
  output fiap_pkg::fiap_freq_type flashReq,
  input wire logic flashDone,
  input wire logic [fiap_pkg::WORD_W-1:0] flashRdata,
  // cpu
  output logic cpuStall
);
  localparam int TW = $clog2(UNLOCK_CYC + 1);
  localparam logic [TW-1:0] TMR_LOAD = TW'(UNLOCK_CYC - 1);
  localparam logic [TW-1:0] TMR_ZERO = '0;
  localparam logic [TW-1:0] TMR_ONE = TW'(1);

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic unlocked;
    logic [2:0] mode;
    logic trig;
    logic pgo;
    logic ren;
    logic rgo;
    logic clr;
    logic [fiap_pkg::ADDR_W-1:0] addr;
    logic [7:0] dlow;
    logic [7:0] dhigh;
    logic [47:0] keys;
    logic [fiap_pkg::KEY_NUM-1:0] fresh;
    logic [TW-1:0] timer;
    logic [fiap_pkg::IDX_W-1:0] ptr;
    logic [fiap_pkg::IDX_W-1:0] idx;
    fiap_pkg::fiap_state_type st;
    fiap_pkg::fiap_freq_type freq;
    logic stall;
  } fiap_regs_type;

  fiap_regs_type q;
  fiap_regs_type d;
  logic bufLoad;
  logic [fiap_pkg::WORD_W-1:0] bufRdata;
  logic bufValid;
  logic wrAcc;
  logic rdAcc;
  logic [7:0] wb;
  logic [6:0] pageSel;
  logic keyMatch;
  logic keysDone;

  ////////////////////////////////////////////////////////////////////////////
  // write buffer
  fiap_buffer #(
    .WORDS(fiap_pkg::PAGE_WORDS),
    .WIDTH(fiap_pkg::WORD_W),
    .IW(fiap_pkg::IDX_W)
  ) uBuf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(q.clr),
    .wrEn(bufLoad),
    .wrIdx(q.ptr),
    .wrData({wb, q.dlow}),
    .rdIdx(q.idx),
    .rdData(bufRdata),
    .rdValid(bufValid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  assign wrAcc = wbReq.cyc && wbReq.stb && wbReq.we && !q.ack && wbReq.sel[0];
  assign rdAcc = wbReq.cyc && wbReq.stb && !q.ack;
  assign wb = wbReq.dat[7:0];
  assign pageSel = q.addr[fiap_pkg::ADDR_W-1:fiap_pkg::IDX_W];
  assign keyMatch = (q.keys == fiap_pkg::KEY_PATTERN);
  assign keysDone = &q.fresh;
  assign bufLoad = wrAcc && wbReq.adr == fiap_pkg::OFS_DATA_HIGH && q.st == fiap_pkg::S_IDLE;

  always_comb begin
    d = q;
    d.ack = rdAcc;
    d.freq.valid = 1'b0;
    if (q.clr) begin
      d.clr = 1'b0;
    end
    // unlock window timer
    if (q.trig) begin
      if (q.timer == TMR_ZERO) begin
        d.trig = 1'b0;
      end else begin
        d.timer = q.timer - TMR_ONE;
      end
    end
    // register writes
    if (wrAcc) begin
      if (wbReq.adr == fiap_pkg::OFS_CTRL0) begin
        d.mode = wb[fiap_pkg::B_MODE +: 3];
        d.ren = wb[fiap_pkg::B_REN];
        if (!wb[fiap_pkg::B_UNL]) begin
          d.unlocked = 1'b0;
        end
        if (wb[fiap_pkg::B_TRIG] && !q.trig &&
            wb[fiap_pkg::B_MODE +: 3] == fiap_pkg::MODE_UNLOCK) begin
          d.trig = 1'b1;
          d.timer = TMR_LOAD;
          d.fresh = '0;
        end
        if (!(wb[fiap_pkg::B_PGO] && wb[fiap_pkg::B_REN] && wb[fiap_pkg::B_RGO]) &&
            q.st == fiap_pkg::S_IDLE) begin
          if (wb[fiap_pkg::B_PGO] && q.unlocked && d.unlocked &&
              (d.mode == fiap_pkg::MODE_WRITE || d.mode == fiap_pkg::MODE_ERASE)) begin
            d.pgo = 1'b1;
            d.idx = fiap_pkg::IDX_FIRST;
            d.freq.addr = {pageSel, fiap_pkg::IDX_FIRST};
            d.freq.cmd = fiap_pkg::CMD_ERASE;
            if (d.mode == fiap_pkg::MODE_ERASE) begin
              d.freq.valid = 1'b1;
              d.st = fiap_pkg::S_ERASE;
            end else begin
              d.st = fiap_pkg::S_PSCAN;
            end
          end else if (wb[fiap_pkg::B_RGO] && d.ren && d.mode == fiap_pkg::MODE_READ) begin
            d.rgo = 1'b1;
            d.freq.valid = 1'b1;
            d.freq.cmd = fiap_pkg::CMD_READ;
            d.freq.addr = q.addr;
            d.st = fiap_pkg::S_READ;
          end
        end
      end else if (wbReq.adr == fiap_pkg::OFS_CTRL2) begin
        if (wb[fiap_pkg::B_CLR]) begin
          d.clr = 1'b1;
        end
      end else if (wbReq.adr == fiap_pkg::OFS_ADDR_LOW) begin
        d.addr[7:0] = wb;
        d.ptr = wb[fiap_pkg::IDX_W-1:0];
      end else if (wbReq.adr == fiap_pkg::OFS_ADDR_HIGH) begin
        d.addr[fiap_pkg::ADDR_W-1:8] = wb[fiap_pkg::ADDR_W-9:0];
      end else if (wbReq.adr == fiap_pkg::OFS_DATA_LOW) begin
        d.dlow = wb;
      end else if (wbReq.adr == fiap_pkg::OFS_DATA_HIGH) begin
        d.dhigh = wb;
        if (q.ptr != fiap_pkg::IDX_LAST) begin
          d.ptr = q.ptr + 5'h01;
        end
      end else if (wbReq.adr >= fiap_pkg::OFS_KEY_BASE &&
                   wbReq.adr < fiap_pkg::OFS_STATUS) begin
        for (int k = 0; k < fiap_pkg::KEY_NUM; k++) begin
          if (wbReq.adr[7:2] == fiap_pkg::OFS_KEY_BASE[7:2] + 6'(k)) begin
            d.keys[8*k +: 8] = wb;
            if (q.trig) begin
              d.fresh[k] = 1'b1;
            end
          end
        end
      end
    end
    // hardware set of unlock wins over a software clear
    if (q.trig && keysDone && keyMatch && q.mode == fiap_pkg::MODE_UNLOCK) begin
      d.unlocked = 1'b1;
    end
    // operation sequencer
    case (q.st)
      fiap_pkg::S_ERASE: begin
        if (flashDone) begin
          d.pgo = 1'b0;
          d.st = fiap_pkg::S_IDLE;
        end
      end
      fiap_pkg::S_PSCAN: begin
        if (bufValid) begin
          d.freq.valid = 1'b1;
          d.freq.cmd = fiap_pkg::CMD_PROG;
          d.freq.addr = {pageSel, q.idx};
          d.freq.wdata = bufRdata;
          d.st = fiap_pkg::S_PWAIT;
        end else if (q.idx == fiap_pkg::IDX_LAST) begin
          d.pgo = 1'b0;
          d.st = fiap_pkg::S_IDLE;
        end else begin
          d.idx = q.idx + 5'h01;
        end
      end
      fiap_pkg::S_PWAIT: begin
        if (flashDone) begin
          if (q.idx == fiap_pkg::IDX_LAST) begin
            d.pgo = 1'b0;
            d.st = fiap_pkg::S_IDLE;
          end else begin
            d.idx = q.idx + 5'h01;
            d.st = fiap_pkg::S_PSCAN;
          end
        end
      end
      fiap_pkg::S_READ: begin
        if (flashDone) begin
          d.dlow = flashRdata[7:0];
          d.dhigh = flashRdata[15:8];
          d.rgo = 1'b0;
          d.st = fiap_pkg::S_IDLE;
        end
      end
      default: begin
      end
    endcase
    d.stall = (d.st != fiap_pkg::S_IDLE);
    // read data
    d.rdat = '0;
    if (wbReq.adr == fiap_pkg::OFS_CTRL0) begin
      d.rdat[7:0] = {q.unlocked, q.mode, q.trig, q.pgo, q.ren, q.rgo};
    end else if (wbReq.adr == fiap_pkg::OFS_CTRL2) begin
      d.rdat[fiap_pkg::B_CLR] = q.clr;
    end else if (wbReq.adr == fiap_pkg::OFS_ADDR_LOW) begin
      d.rdat[7:0] = q.addr[7:0];
    end else if (wbReq.adr == fiap_pkg::OFS_ADDR_HIGH) begin
      d.rdat[fiap_pkg::ADDR_W-9:0] = q.addr[fiap_pkg::ADDR_W-1:8];
    end else if (wbReq.adr == fiap_pkg::OFS_DATA_LOW) begin
      d.rdat[7:0] = q.dlow;
    end else if (wbReq.adr == fiap_pkg::OFS_DATA_HIGH) begin
      d.rdat[7:0] = q.dhigh;
    end else if (wbReq.adr >= fiap_pkg::OFS_KEY_BASE &&
                 wbReq.adr < fiap_pkg::OFS_STATUS) begin
      for (int k = 0; k < fiap_pkg::KEY_NUM; k++) begin
        if (wbReq.adr[7:2] == fiap_pkg::OFS_KEY_BASE[7:2] + 6'(k)) begin
          d.rdat[7:0] = q.keys[8*k +: 8];
        end
      end
    end else if (wbReq.adr == fiap_pkg::OFS_STATUS) begin
      d.rdat[7:0] = {2'h0, q.ptr, q.stall};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= fiap_pkg::S_IDLE;
    end else begin
      q <= d;
    end
  end

  assign wbAck = q.ack;
  assign wbDatR = q.rdat;
  assign flashReq = q.freq;
  assign cpuStall = q.stall;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_window_min: assert property ($rose(q.trig) |-> q.trig [*8])
    else $error("unlock window too short");
  a_window_end: assert property (q.trig && q.timer == TMR_ZERO |=> !q.trig)
    else $error("unlock trigger not cleared at expiry");
  a_unlock_cause: assert property ($rose(q.unlocked) |->
    $past(q.trig) && $past(keyMatch) && $past(keysDone))
    else $error("unlock without full key match");
  a_sw_clear: assert property (wrAcc && wbReq.adr == fiap_pkg::OFS_CTRL0 &&
    !wb[fiap_pkg::B_UNL] && !(q.trig && keysDone && keyMatch) |=> !q.unlocked)
    else $error("unlock survives software clear");
  a_ptr_hold: assert property (bufLoad && q.ptr == fiap_pkg::IDX_LAST |=>
    q.ptr == fiap_pkg::IDX_LAST) else $error("buffer address passed page end");
  a_combo_refuse: assert property (wrAcc && wbReq.adr == fiap_pkg::OFS_CTRL0 &&
    q.st == fiap_pkg::S_IDLE && wb[fiap_pkg::B_PGO] && wb[fiap_pkg::B_REN] &&
    wb[fiap_pkg::B_RGO] |=> !q.pgo && !q.rgo) else $error("combined go accepted");
  a_erase_page: assert property (q.freq.valid && q.freq.cmd == fiap_pkg::CMD_ERASE |->
    q.freq.addr[fiap_pkg::IDX_W-1:0] == fiap_pkg::IDX_FIRST) else $error("erase not page");
  a_stall_op: assert property (q.pgo || q.rgo |-> q.stall)
    else $error("cpu not stalled during operation");
  a_read_done: assert property (q.st == fiap_pkg::S_READ && flashDone |=>
    !q.rgo && q.dlow == $past(flashRdata[7:0])) else $error("read result not taken");
  a_ack_pulse: assert property (wbReq.cyc && wbReq.stb && !q.ack |=> q.ack ##1 !q.ack)
    else $error("wishbone ack not a single pulse");

  c_unlock: cover property ($rose(q.unlocked));
  c_erase: cover property (q.st == fiap_pkg::S_ERASE ##1 q.st == fiap_pkg::S_IDLE);
  c_program: cover property (q.st == fiap_pkg::S_PWAIT && flashDone &&
    q.idx == fiap_pkg::IDX_LAST);
  c_read: cover property ($fell(q.rgo));
endmodule
`default_nettype wire

// >>> sim/fiap_flash_model.sv
`default_nettype none
module fiap_flash_model #(
  parameter int LAT = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // request side
  input wire fiap_pkg::fiap_freq_type flashReq,
  output logic flashDone,
  output logic [15:0] flashRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [4096];
  fiap_pkg::fiap_freq_type op;
  logic busy;
  int cnt;
  int progCount;
  initial begin
    flashDone = 1'b0;
    flashRdata = 16'h0000;
    progCount = 0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 16'(i) ^ 16'h3c3c;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // erase and program take longer than a read
  always @(posedge mclk) begin
    flashDone <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= 0;
    end else if (flashReq.valid) begin
      busy <= 1'b1;
      op <= flashReq;
      cnt <= (flashReq.cmd == fiap_pkg::CMD_READ) ? LAT : 4 * LAT;
    end else if (busy && cnt > 1) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      busy <= 1'b0;
      flashDone <= 1'b1;
      case (op.cmd)
        fiap_pkg::CMD_READ: flashRdata <= mem[op.addr];
        fiap_pkg::CMD_ERASE: begin
          for (int i = 0; i < 32; i++) begin
            mem[{op.addr[11:5], 5'(i)}] <= 16'h0000;
          end
        end
        default: begin
          mem[op.addr] <= op.wdata;
          progCount <= progCount + 1;
        end
      endcase
    end else begin
      // released data lines do not keep the last word
      flashRdata <= ~flashRdata;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic we; logic [7:0] adr; logic [7:0] dat;} fiap_row_type;
  localparam fiap_row_type ROWS [8] = '{
    '{1'b0, 8'h00, 8'h00}, '{1'b0, 8'h30, 8'h00}, '{1'b1, 8'h00, 8'h80},
    '{1'b0, 8'h00, 8'h00}, '{1'b1, 8'h3c, 8'hff}, '{1'b0, 8'h3c, 8'h00},
    '{1'b1, 8'h08, 8'h5a}, '{1'b0, 8'h08, 8'h5a}};
  localparam logic [7:0] KEYS [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  localparam logic [11:0] PB = 12'h4a0;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  fiap_pkg::fiap_wbreq_type wbReq = '0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic flashDone;
  logic cpuStall;
  logic [15:0] flashRdata;
  fiap_pkg::fiap_freq_type flashReq;
  int mismatches = 0;
  int nCompared = 0;
  int stallCycles = 0;
  int p0;
  logic [7:0] r;
  logic [7:0] lo;
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (cpuStall === 1'b1) stallCycles <= stallCycles + 1;
  fiap_ctrl #(.UNLOCK_CYC(32)) uut (.mclk(mclk), .sys_rst(sys_rst), .wbReq(wbReq),
    .wbDatR(wbDatR), .wbAck(wbAck), .flashReq(flashReq), .flashDone(flashDone),
    .flashRdata(flashRdata), .cpuStall(cpuStall));
  fiap_flash_model #(.LAT(3)) flash (.mclk(mclk), .sys_rst(sys_rst), .flashReq(flashReq),
    .flashDone(flashDone), .flashRdata(flashRdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    wbReq <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
    do begin
      @(posedge mclk);
    end while (wbAck !== 1'b1);
    r = wbDatR[7:0];
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_clear(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h00, 8'h00);
      n++;
    end while (r[b] !== 1'b0 && n < 1000);
    if (r[b] !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: go bit %0d never cleared", $time, b);
    end
  endtask
  task automatic keys(input logic [7:0] last);
    for (int k = 0; k < 6; k++) begin
      wb(1'b1, 8'h18 + 8'(4 * k), (k == 5) ? last : KEYS[k]);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d compared %0d", mismatches, nCompared);
    if (mismatches == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    foreach (ROWS[i]) begin
      wb(ROWS[i].we, ROWS[i].adr, ROWS[i].dat);
      if (!ROWS[i].we) chk(r, ROWS[i].dat);
    end
    // read while locked, first without read_enable
    wb(1'b1, 8'h08, 8'h23);
    wb(1'b1, 8'h0c, 8'h01);
    wb(1'b1, 8'h00, 8'h31);
    wb(1'b0, 8'h00, 8'h00);
    chk(r[0], 1'b0);
    stallCycles = 0;
    wb(1'b1, 8'h00, 8'h33);
    wait_clear(0);
    chk((stallCycles > 0 && stallCycles < 12), 1'b1);
    wb(1'b0, 8'h10, 8'h00);
    chk(r, 8'h1f);
    wb(1'b0, 8'h14, 8'h00);
    chk(r, 8'h3d);
    // all three go bits together, then program while locked
    wb(1'b1, 8'h00, 8'h37);
    wb(1'b0, 8'h00, 8'h00);
    chk(r & 8'h05, 8'h00);
    wb(1'b1, 8'h00, 8'h04);
    wb(1'b0, 8'h00, 8'h00);
    chk(r[2], 1'b0);
    // wrong key, then keys outside a window, then the right keys
    wb(1'b1, 8'h00, 8'h68);
    keys(8'h41);
    wb(1'b0, 8'h00, 8'h00);
    chk(r[7], 1'b0);
    repeat (40) @(posedge mclk);
    wb(1'b0, 8'h00, 8'h00);
    chk(r[3], 1'b0);
    keys(8'h40);
    wb(1'b0, 8'h00, 8'h00);
    chk(r[7], 1'b0);
    wb(1'b1, 8'h00, 8'h68);
    keys(8'h40);
    wb(1'b0, 8'h00, 8'h00);
    chk(r[7], 1'b1);
    repeat (40) @(posedge mclk);
    wb(1'b0, 8'h00, 8'h00);
    chk(r & 8'h88, 8'h80);
    // erase with two tagged addresses
    wb(1'b1, 8'h00, 8'h90);
    wb(1'b1, 8'h08, 8'ha0);
    wb(1'b1, 8'h0c, 8'h04);
    wb(1'b1, 8'h14, 8'hff);
    wb(1'b1, 8'h14, 8'hff);
    wb(1'b1, 8'h00, 8'h94);
    wait_clear(2);
    chk(flash.mem[PB], 16'h0000);
    chk(flash.mem[PB + 12'd31], 16'h0000);
    chk(flash.mem[PB + 12'd32], (PB + 16'd32) ^ 16'h3c3c);
    // blank check of the first erased word through a read
    wb(1'b1, 8'h00, 8'hb3);
    wait_clear(0);
    wb(1'b0, 8'h10, 8'h00);
    chk(r, 8'h00);
    wb(1'b0, 8'h14, 8'h00);
    chk(r, 8'h00);
    // load 33 words, the last one lands on the last index
    wb(1'b1, 8'h00, 8'h80);
    wb(1'b1, 8'h08, 8'ha0);
    for (int i = 0; i < 33; i++) begin
      lo = (i == 32) ? 8'hef : 8'(i);
      wb(1'b1, 8'h10, lo);
      wb(1'b1, 8'h14, (i == 32) ? 8'hbe : 8'h12);
    end
    wb(1'b0, 8'h30, 8'h00);
    chk(r[5:1], 5'h1f);
    wb(1'b1, 8'h00, 8'h84);
    wait_clear(2);
    for (int i = 0; i < 31; i++) begin
      chk(flash.mem[PB + 12'(i)], {8'h12, 8'(i)});
    end
    chk(flash.mem[PB + 12'd31], 16'hbeef);
    // clear, reload one word and program again without erase
    p0 = flash.progCount;
    wb(1'b1, 8'h04, 8'h01);
    wb(1'b1, 8'h08, 8'ha3);
    wb(1'b1, 8'h10, 8'h77);
    wb(1'b1, 8'h14, 8'h66);
    wb(1'b1, 8'h00, 8'h84);
    wait_clear(2);
    chk(flash.mem[PB + 12'd3], 16'h6677);
    chk(16'(flash.progCount - p0), 16'h0001);
    // software lock, then a refused program
    wb(1'b1, 8'h00, 8'h00);
    wb(1'b1, 8'h00, 8'h04);
    wb(1'b0, 8'h00, 8'h00);
    chk(r & 8'h84, 8'h00);
    // reset in mid-run returns the buffer address and registers to zero
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    wb(1'b0, 8'h30, 8'h00);
    chk(r, 8'h00);
    wb(1'b0, 8'h08, 8'h00);
    chk(r, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
